//--- verilog/sprx_pkg.sv
package sprx_pkg;

   // ---------------------------------------------------------------
   // Word layout inside the per-port receive FIFOs
   // ---------------------------------------------------------------
   localparam int DATA_W    = 32;
   localparam int WORD_W    = 36;
   localparam int W_EOP_BIT = 32;
   localparam int W_MOD_LSB = 33;
   localparam int W_ERR_BIT = 35;

   // ---------------------------------------------------------------
   // Register map and fields
   // ---------------------------------------------------------------
   localparam int          REG_ADDR_W     = 4;
   localparam logic [3:0]  REG_CTRL_ADDR  = 4'h0;
   localparam logic [3:0]  REG_STAT_ADDR  = 4'h4;
   localparam int          CTRL_AE_LSB    = 0;
   localparam int          CTRL_GAP_LSB   = 8;
   localparam int          CTRL_BURST_LSB = 12;
   localparam int          CTRL_BEN_BIT   = 20;
   localparam int          CTRL_ODD_BIT   = 24;
   localparam int          STAT_RDY_LSB   = 0;
   localparam int          STAT_PORT_LSB  = 8;
   localparam int          STAT_ST_LSB    = 12;
   localparam logic [3:0]  AE_RST         = 4'h4;
   localparam logic [2:0]  GAP_RST        = 3'h0;
   localparam logic [6:0]  BURST_RST      = 7'h10;
   localparam logic [6:0]  BURST_MIN_WORDS = 7'h02;
   localparam logic [6:0]  BURST_MAX_WORDS = 7'h40;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DATA = 2'b01,
      ST_GAP  = 2'b10
   } sprx_state_e;

endpackage

//--- verilog/sprx_fifo_if.sv
`timescale 1ns/10ps
interface sprx_fifo_if #(
   parameter int WIDTH = 36,
   parameter int LVL_W = 5
);
   logic             wr_valid;
   logic             wr_ready;
   logic [WIDTH-1:0] wr_data;
   logic             rd_valid;
   logic             rd_ready;
   logic [WIDTH-1:0] rd_data;
   logic [LVL_W-1:0] level;

   modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data, level);
   modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data, level);
endinterface

//--- verilog/sprx_fifo.sv
`timescale 1ns/10ps
module sprx_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 16
) (
   input  wire logic  mclk_i,    // System clock.
   input  wire logic  resetn_i,  // Asynchronous reset, active low.
   sprx_fifo_if.fifo  fif        // Write and read sides.
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp_reg;
   logic [AW-1:0]    rp_reg;
   logic [AW:0]      cnt_reg;
   logic             ov_reg;
   logic [WIDTH-1:0] od_reg;
   logic             push;
   logic             load;

   // The output word sits in a register in front of the array, so the
   // array never needs to be read combinationally by the consumer.
   assign fif.wr_ready = (cnt_reg != (AW+1)'(DEPTH));
   assign push         = fif.wr_valid && fif.wr_ready;
   assign load         = (cnt_reg != '0) && (!ov_reg || fif.rd_ready);
   assign fif.rd_valid = ov_reg;
   assign fif.rd_data  = od_reg;
   assign fif.level    = $bits(fif.level)'(cnt_reg) + $bits(fif.level)'(ov_reg);

   always_ff @(posedge mclk_i) begin
      if (push) begin
         mem[wp_reg] <= fif.wr_data;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wp_reg  <= '0;
         rp_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
         end
         if (load) begin
            rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
         end
         if (push && !load) begin
            cnt_reg <= cnt_reg + 1'b1;
         end else if (load && !push) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ov_reg <= 1'b0;
         od_reg <= '0;
      end else if (load) begin
         ov_reg <= 1'b1;
         od_reg <= mem[rp_reg];
      end else if (fif.rd_ready) begin
         ov_reg <= 1'b0;
      end
   end
endmodule

//--- verilog/sprx_rr_arb.sv
`timescale 1ns/10ps
module sprx_rr_arb #(
   parameter int N  = 4,
   parameter int PW = 2
) (
   input  wire logic [N-1:0]  req_i,    // Ports that may start a transfer.
   input  wire logic [PW-1:0] last_i,   // Port served last.
   output logic      [PW-1:0] grant_o,  // Next port in ascending order.
   output logic               found_o   // Some port is requesting.
);
   always_comb begin
      int idx;
      idx     = 0;
      grant_o = last_i;
      found_o = 1'b0;
      // Search starts just above the last port and wraps, so every port
      // is offered a turn before any port gets a second one.
      for (int k = N; k >= 1; k--) begin
         idx = (int'(last_i) + k) % N;
         if (req_i[idx]) begin
            grant_o = PW'(idx);
            found_o = 1'b1;
         end
      end
   end
endmodule

//--- verilog/sprx_rx_push.sv
`timescale 1ns/10ps
// How it works
// - Device picks port, pushes only when ready
// - One physical device only on bus
// - Flag first and last packet words
// - Raise error flag on errored packet
// - Byte count on last word
// - Flag port address word on bus
// - Valid only with real packet data
// - Parity over data bus per word
// - All timing on link clock, bus driven
// - Round robin in ascending port order
// - Start when not almost empty or a packet end is held
// - End on burst, empty, or starved end
// - Next transfer from next ready port
// - Programmable 0-7 idle cycles after ends
// - Keep same port when alone and ready
// - Burst 8-256 bytes or disabled
module sprx_rx_push
   import sprx_pkg::*;
#(
   parameter int NUM_PORTS  = 4,
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic                            mclk_i,                    // System clock.
   input  wire logic                            resetn_i,                  // Async reset.
   input  wire logic                            rx_iface_clock_i,          // Link clock pin.
   input  wire logic                            rx_enable_n_i,             // Link accepts.
   output logic      [DATA_W-1:0]               rx_data_o,                 // Data bus.
   output logic                                 rx_bus_parity_o,           // Bus parity.
   output logic                                 rx_packet_start_flag_o,    // First word.
   output logic                                 rx_packet_end_flag_o,      // Last word.
   output logic                                 rx_packet_error_flag_o,    // Errored packet.
   output logic                                 rx_word_valid_o,           // Data valid.
   output logic                                 rx_port_address_flag_o,    // Address word.
   output logic      [1:0]                      rx_last_word_byte_count_o, // Modulus.
   input  wire logic [NUM_PORTS-1:0]            pkt_wr_valid_i,            // Word offered.
   input  wire logic [NUM_PORTS-1:0][DATA_W-1:0] pkt_wr_data_i,            // Word data.
   input  wire logic [NUM_PORTS-1:0]            pkt_wr_eop_i,              // Packet end.
   input  wire logic [NUM_PORTS-1:0]            pkt_wr_err_i,              // Packet error.
   input  wire logic [NUM_PORTS-1:0][1:0]       pkt_wr_mod_i,              // Last bytes.
   output logic      [NUM_PORTS-1:0]            pkt_wr_ready_o,            // FIFO has room.
   input  wire logic [REG_ADDR_W-1:0]           reg_addr_i,                // Register addr.
   input  wire logic [31:0]                     reg_wdata_i,               // Write data.
   input  wire logic                            reg_wr_i,                  // Write strobe.
   input  wire logic                            reg_rd_i,                  // Read strobe.
   output logic      [31:0]                     reg_rdata_o                // Read data.
);
   localparam int PW    = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;
   localparam int LVL_W = $clog2(FIFO_DEPTH + 2);

   // ---------------------------------------------------------------
   // Link clock and enable sampling
   // ---------------------------------------------------------------
   logic       lclk_s1_reg;
   logic       lclk_s2_reg;
   logic       lclk_s3_reg;
   logic       ren_s1_reg;
   logic       ren_s2_reg;
   logic       tick;
   logic       step;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lclk_s1_reg <= 1'b0;
         lclk_s2_reg <= 1'b0;
         lclk_s3_reg <= 1'b0;
         ren_s1_reg  <= 1'b1;
         ren_s2_reg  <= 1'b1;
      end else begin
         lclk_s1_reg <= rx_iface_clock_i;
         lclk_s2_reg <= lclk_s1_reg;
         lclk_s3_reg <= lclk_s2_reg;
         ren_s1_reg  <= rx_enable_n_i;
         ren_s2_reg  <= ren_s1_reg;
      end
   end

   // Each rising edge of the link clock becomes one enable pulse; the
   // link clock must stay well below half the system clock rate.
   assign tick = lclk_s2_reg && !lclk_s3_reg;
   assign step = tick && !ren_s2_reg;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [3:0]  cfg_ae_reg;
   logic [2:0]  cfg_gap_reg;
   logic [6:0]  cfg_burst_reg;
   logic        cfg_ben_reg;
   logic        cfg_odd_reg;
   sprx_state_e state_reg;
   logic [PW-1:0] cur_reg;
   logic [NUM_PORTS-1:0] ready;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cfg_ae_reg    <= AE_RST;
         cfg_gap_reg   <= GAP_RST;
         cfg_burst_reg <= BURST_RST;
         cfg_ben_reg   <= 1'b1;
         cfg_odd_reg   <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == REG_CTRL_ADDR) begin
         cfg_ae_reg    <= reg_wdata_i[CTRL_AE_LSB +: 4];
         cfg_gap_reg   <= reg_wdata_i[CTRL_GAP_LSB +: 3];
         cfg_burst_reg <= reg_wdata_i[CTRL_BURST_LSB +: 7];
         cfg_ben_reg   <= reg_wdata_i[CTRL_BEN_BIT];
         cfg_odd_reg   <= reg_wdata_i[CTRL_ODD_BIT];
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         reg_rdata_o <= '0;
      end else if (reg_rd_i) begin
         reg_rdata_o <= '0;
         case (reg_addr_i)
            REG_CTRL_ADDR: begin
               reg_rdata_o[CTRL_AE_LSB +: 4]    <= cfg_ae_reg;
               reg_rdata_o[CTRL_GAP_LSB +: 3]   <= cfg_gap_reg;
               reg_rdata_o[CTRL_BURST_LSB +: 7] <= cfg_burst_reg;
               reg_rdata_o[CTRL_BEN_BIT]        <= cfg_ben_reg;
               reg_rdata_o[CTRL_ODD_BIT]        <= cfg_odd_reg;
            end
            REG_STAT_ADDR: begin
               reg_rdata_o[STAT_RDY_LSB +: NUM_PORTS] <= ready;
               reg_rdata_o[STAT_PORT_LSB +: PW]       <= cur_reg;
               reg_rdata_o[STAT_ST_LSB +: 2]          <= state_reg;
            end
            default: begin
               reg_rdata_o <= '0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Per-port FIFOs and fill state
   // ---------------------------------------------------------------
   logic [NUM_PORTS-1:0][WORD_W-1:0] rd_word;
   logic [NUM_PORTS-1:0]             rd_valid;
   logic [NUM_PORTS-1:0][LVL_W-1:0]  level;
   logic [LVL_W-1:0]                 eop_cnt [NUM_PORTS];
   logic                             pop;
   logic [LVL_W-1:0]                 ae_level;

   assign ae_level = LVL_W'(cfg_ae_reg);

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      sprx_fifo_if #(.WIDTH(WORD_W), .LVL_W(LVL_W)) fif ();
      logic push_eop;
      logic pop_eop;

      assign fif.wr_valid = pkt_wr_valid_i[p];
      assign fif.wr_data  = {pkt_wr_err_i[p], pkt_wr_mod_i[p], pkt_wr_eop_i[p], pkt_wr_data_i[p]};
      assign fif.rd_ready = pop && (cur_reg == PW'(p));
      assign pkt_wr_ready_o[p] = fif.wr_ready;
      assign rd_word[p]   = fif.rd_data;
      assign rd_valid[p]  = fif.rd_valid;
      assign level[p]     = fif.level;
      assign push_eop     = fif.wr_valid && fif.wr_ready && pkt_wr_eop_i[p];
      assign pop_eop      = fif.rd_ready && fif.rd_data[W_EOP_BIT];

      // Counting packet ends held lets a short final packet go out even
      // when the fill stays below the almost-empty level.
      always_ff @(posedge mclk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            eop_cnt[p] <= '0;
         end else if (push_eop && !pop_eop) begin
            eop_cnt[p] <= eop_cnt[p] + 1'b1;
         end else if (pop_eop && !push_eop) begin
            eop_cnt[p] <= eop_cnt[p] - 1'b1;
         end
      end

      assign ready[p] = (level[p] > ae_level) || (eop_cnt[p] != '0);

      sprx_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
         .mclk_i   (mclk_i),
         .resetn_i (resetn_i),
         .fif      (fif)
      );
   end

   // ---------------------------------------------------------------
   // Arbitration and transfer decisions
   // ---------------------------------------------------------------
   logic [PW-1:0]        grant;
   logic                 found;
   logic [NUM_PORTS-1:0] cur_mask;
   logic                 others;
   logic [WORD_W-1:0]    word;
   logic                 w_eop;
   logic                 ae_after;
   logic                 burst_hit;
   logic                 emptied;
   logic                 xfer_end;
   logic                 stay_now;
   logic                 stay_gap;
   logic [6:0]           burst_lim;
   logic [6:0]           burst_cnt_reg;
   logic                 xend_reg;
   logic [2:0]           gap_cnt_reg;
   logic [NUM_PORTS-1:0] sop_pend_reg;

   sprx_rr_arb #(.N(NUM_PORTS), .PW(PW)) u_arb (
      .req_i   (ready),
      .last_i  (cur_reg),
      .grant_o (grant),
      .found_o (found)
   );

   assign cur_mask = NUM_PORTS'(1) << cur_reg;
   assign others   = |(ready & ~cur_mask);
   assign word     = rd_word[cur_reg];
   assign w_eop    = word[W_EOP_BIT];
   assign pop      = step && (state_reg == ST_DATA) && rd_valid[cur_reg];

   always_comb begin
      burst_lim = cfg_burst_reg;
      if (cfg_burst_reg < BURST_MIN_WORDS) begin
         burst_lim = BURST_MIN_WORDS;
      end else if (cfg_burst_reg > BURST_MAX_WORDS) begin
         burst_lim = BURST_MAX_WORDS;
      end
   end

   // Fill state as it will be once the word now leaving is gone.
   assign ae_after  = !(((level[cur_reg] - 1'b1) > ae_level) ||
                        ((eop_cnt[cur_reg] - LVL_W'(w_eop)) != '0));
   assign burst_hit = cfg_ben_reg && ((burst_cnt_reg + 7'h01) >= burst_lim);
   assign emptied   = (level[cur_reg] == LVL_W'(1));
   assign xfer_end  = burst_hit || emptied || (w_eop && ae_after);
   assign stay_now  = !xfer_end && !others && !ae_after;
   assign stay_gap  = !xend_reg && !others && ready[cur_reg];

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg   <= ST_IDLE;
         cur_reg     <= PW'(NUM_PORTS - 1);
         xend_reg    <= 1'b0;
         gap_cnt_reg <= '0;
      end else if (step) begin
         case (state_reg)
            ST_IDLE: begin
               if (found) begin
                  cur_reg   <= grant;
                  state_reg <= ST_DATA;
               end
            end
            ST_DATA: begin
               if (!rd_valid[cur_reg]) begin
                  state_reg <= ST_IDLE;
               end else if (w_eop || xfer_end) begin
                  xend_reg    <= xfer_end;
                  gap_cnt_reg <= cfg_gap_reg;
                  if (cfg_gap_reg != '0) begin
                     state_reg <= ST_GAP;
                  end else if (!stay_now) begin
                     state_reg <= ST_IDLE;
                  end
               end
            end
            ST_GAP: begin
               gap_cnt_reg <= gap_cnt_reg - 1'b1;
               if (gap_cnt_reg == 3'h1) begin
                  state_reg <= stay_gap ? ST_DATA : ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         burst_cnt_reg <= '0;
      end else if (step && state_reg == ST_IDLE) begin
         burst_cnt_reg <= '0;
      end else if (pop) begin
         burst_cnt_reg <= burst_cnt_reg + 7'h01;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sop_pend_reg <= '1;
      end else if (pop) begin
         sop_pend_reg[cur_reg] <= w_eop;
      end
   end

   // ---------------------------------------------------------------
   // Link outputs
   // ---------------------------------------------------------------
   // Only the one device on this bus drives it, so the data lines are
   // never released.
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rx_data_o                 <= '0;
         rx_word_valid_o           <= 1'b0;
         rx_port_address_flag_o    <= 1'b0;
         rx_packet_start_flag_o    <= 1'b0;
         rx_packet_end_flag_o      <= 1'b0;
         rx_packet_error_flag_o    <= 1'b0;
         rx_last_word_byte_count_o <= '0;
      end else if (step) begin
         rx_word_valid_o           <= 1'b0;
         rx_port_address_flag_o    <= 1'b0;
         rx_packet_start_flag_o    <= 1'b0;
         rx_packet_end_flag_o      <= 1'b0;
         rx_packet_error_flag_o    <= 1'b0;
         rx_last_word_byte_count_o <= '0;
         if (state_reg == ST_IDLE && found) begin
            rx_data_o              <= DATA_W'(grant);
            rx_port_address_flag_o <= 1'b1;
         end else if (pop) begin
            rx_data_o                 <= word[DATA_W-1:0];
            rx_word_valid_o           <= 1'b1;
            rx_packet_start_flag_o    <= sop_pend_reg[cur_reg];
            rx_packet_end_flag_o      <= w_eop;
            rx_packet_error_flag_o    <= w_eop && word[W_ERR_BIT];
            rx_last_word_byte_count_o <= w_eop ? word[W_MOD_LSB +: 2] : 2'b00;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rx_bus_parity_o <= 1'b1;
      end else if (step) begin
         if (state_reg == ST_IDLE && found) begin
            rx_bus_parity_o <= ^DATA_W'(grant) ^ cfg_odd_reg;
         end else if (pop) begin
            rx_bus_parity_o <= ^word[DATA_W-1:0] ^ cfg_odd_reg;
         end
      end
   end
endmodule

//--- sim/sprx_rx_push_monitor.sv
`timescale 1ns/10ps
module sprx_rx_push_monitor (
   input wire logic        mclk_i,                    // System clock.
   input wire logic        resetn_i,                  // Reset, active low.
   input wire logic        rx_iface_clock_i,          // Link clock.
   input wire logic        rx_enable_n_i,             // Link accepts when low.
   input wire logic [31:0] rx_data_o,                 // Data bus.
   input wire logic        rx_bus_parity_o,           // Parity.
   input wire logic        rx_packet_start_flag_o,    // First word.
   input wire logic        rx_packet_end_flag_o,      // Last word.
   input wire logic        rx_packet_error_flag_o,    // Error.
   input wire logic        rx_word_valid_o,           // Valid.
   input wire logic        rx_port_address_flag_o,    // Address word.
   input wire logic [1:0]  rx_last_word_byte_count_o  // Modulus.
);
   // ------------------------------------------------------------
   // Helpers: enable-high run length and age of the last link edge.
   // ------------------------------------------------------------
   logic [2:0] hi_cnt;
   logic [3:0] rise_age;
   logic       lclk_q;
   logic [38:0] outs;
   assign outs = {rx_data_o, rx_bus_parity_o, rx_packet_start_flag_o, rx_packet_end_flag_o,
                  rx_packet_error_flag_o, rx_word_valid_o, rx_port_address_flag_o,
                  rx_last_word_byte_count_o};
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) hi_cnt <= 3'h0;
      else if (!rx_enable_n_i) hi_cnt <= 3'h0;
      else if (hi_cnt != 3'h7) hi_cnt <= hi_cnt + 3'h1;
   end
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lclk_q   <= 1'b0;
         rise_age <= 4'hF;
      end else begin
         lclk_q <= rx_iface_clock_i;
         if (rx_iface_clock_i && !lclk_q) rise_age <= 4'h0;
         else if (rise_age != 4'hF) rise_age <= rise_age + 4'h1;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   property p_addr_novalid; rx_port_address_flag_o |-> !rx_word_valid_o; endproperty
   a_addr_novalid: assert property (p_addr_novalid) else $error("address word with valid");
   property p_addr_port;
      rx_port_address_flag_o |-> rx_data_o < 32'h4 && !rx_packet_start_flag_o;
   endproperty
   a_addr_port: assert property (p_addr_port) else $error("bad address word");
   property p_start_valid; rx_packet_start_flag_o |-> rx_word_valid_o; endproperty
   a_start_valid: assert property (p_start_valid) else $error("start without valid");
   property p_end_valid; rx_packet_end_flag_o |-> rx_word_valid_o; endproperty
   a_end_valid: assert property (p_end_valid) else $error("end without valid");
   property p_err_end; rx_packet_error_flag_o |-> rx_packet_end_flag_o; endproperty
   a_err_end: assert property (p_err_end) else $error("error off last word");
   property p_mod_end; (rx_last_word_byte_count_o != 2'h0) |-> rx_packet_end_flag_o; endproperty
   a_mod_end: assert property (p_mod_end) else $error("modulus off last word");
   property p_tick; $changed(outs) |-> rise_age <= 4'h6; endproperty
   a_tick: assert property (p_tick) else $error("output moved away from link edge");
   property p_hold; hi_cnt == 3'h7 |-> $stable(outs); endproperty
   a_hold: assert property (p_hold) else $error("output moved while link paused");
endmodule
bind sprx_rx_push sprx_rx_push_monitor u_mon (.mclk_i, .resetn_i, .rx_iface_clock_i,
   .rx_enable_n_i, .rx_data_o, .rx_bus_parity_o, .rx_packet_start_flag_o,
   .rx_packet_end_flag_o, .rx_packet_error_flag_o, .rx_word_valid_o,
   .rx_port_address_flag_o, .rx_last_word_byte_count_o);

//--- sim/sprx_link_model.sv
`timescale 1ns/10ps
module sprx_link_model (
   output logic            lclk_o,  // Link clock, free running.
   output logic            en_n_o,  // Accept, active low.
   input  wire logic       stall_i, // Bench asks for a pause.
   input  wire logic [38:0] word_i, // Packed bus outputs.
   input  wire logic       take_i   // Valid or address word.
);
   logic [38:0] q[$];
   logic        en_prev;
   // The enable moves on the falling edge so it is settled well before the next rise.
   initial begin
      lclk_o  = 1'b0;
      en_n_o  = 1'b1;
      en_prev = 1'b1;
      #137;
      forever begin
         #400 lclk_o = 1'b1;
         if (!en_prev && take_i) q.push_back(word_i);
         en_prev = en_n_o;
         #400 lclk_o = 1'b0;
         en_n_o = stall_i;
      end
   end
endmodule

//--- sim/sprx_rx_push_tb.sv
`timescale 1ns/10ps
module sprx_rx_push_tb;
   import sprx_pkg::*;
   logic mclk_i, resetn_i, lclk, en_n, stall, rwr, rrd, par, sf, ef, erf, vf, af;
   logic [3:0] wv, we, werr, rdy, ra;
   logic [3:0][31:0] wd;
   logic [3:0][1:0] wm;
   logic [31:0] rwd, rdat, dat;
   logic [1:0] md;
   int n_errors, samples_checked;
   sprx_rx_push uut (.mclk_i, .resetn_i, .rx_iface_clock_i(lclk), .rx_enable_n_i(en_n),
      .rx_data_o(dat), .rx_bus_parity_o(par), .rx_packet_start_flag_o(sf),
      .rx_packet_end_flag_o(ef), .rx_packet_error_flag_o(erf), .rx_word_valid_o(vf),
      .rx_port_address_flag_o(af), .rx_last_word_byte_count_o(md), .pkt_wr_valid_i(wv),
      .pkt_wr_data_i(wd), .pkt_wr_eop_i(we), .pkt_wr_err_i(werr), .pkt_wr_mod_i(wm),
      .pkt_wr_ready_o(rdy), .reg_addr_i(ra), .reg_wdata_i(rwd), .reg_wr_i(rwr),
      .reg_rd_i(rrd), .reg_rdata_o(rdat));
   sprx_link_model link (.lclk_o(lclk), .en_n_o(en_n), .stall_i(stall),
      .word_i({af, sf, ef, erf, md, par, dat}), .take_i(vf | af));
   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end
   task automatic final_report();
      $display("checked %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input string nm, input logic [38:0] seen, input logic [38:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic [38:0] wrd(logic a, logic s, logic e, logic r, logic [1:0] m,
                                       logic [31:0] d);
      return {a, s, e, r, m, ~^d, d};
   endfunction
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      ra <= a; rwd <= d; rwr <= 1'b1;
      @(posedge mclk_i);
      rwr <= 1'b0;
   endtask
   task automatic reg_chk(input logic [3:0] a, input logic [31:0] exp);
      @(posedge mclk_i);
      ra <= a; rrd <= 1'b1;
      @(posedge mclk_i);
      rrd <= 1'b0;
      @(negedge mclk_i);
      check("register", {7'h0, rdat}, {7'h0, exp});
   endtask
   task automatic pkt(input int p, input int n, input logic [31:0] b, input logic close);
      int i;
      int k;
      @(posedge mclk_i);
      for (i = 0; i < n; i++) begin
         wv[p] <= 1'b1; wd[p] <= b + 32'(i); we[p] <= close && i == n - 1;
         werr[p] <= 1'b1; wm[p] <= 2'h3;
         k = 0;
         do begin @(posedge mclk_i); k++; end while (rdy[p] !== 1'b1 && k < 50);
         if (rdy[p] !== 1'b1) begin n_errors++; final_report(); end
      end
      wv[p] <= 1'b0;
   endtask
   task automatic pop(output logic [38:0] w);
      int k;
      for (k = 0; k < 2000 && link.q.size() == 0; k++) @(posedge mclk_i);
      if (link.q.size() == 0) begin
         n_errors++;
         final_report();
      end
      w = link.q.pop_front();
   endtask
   task automatic exp_pkt(input int p, input int n, input logic [31:0] b);
      logic [38:0] w;
      int i;
      pop(w);
      check("address word", w, wrd(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 32'(p)));
      for (i = 0; i < n; i++) begin
         pop(w);
         check("data word", w, wrd(1'b0, i == 0, i == n - 1, i == n - 1,
                                   (i == n - 1) ? 2'h3 : 2'h0, b + 32'(i)));
      end
   endtask
   task automatic t_regs();
      reg_chk(REG_CTRL_ADDR, 32'h0111_0004);
      reg_chk(REG_STAT_ADDR, 32'h0000_0300);
      reg_chk(4'hC, 32'h0000_0000);
   endtask
   task automatic t_rr();
      pkt(1, 2, 32'hA5A5_0000, 1'b1);
      exp_pkt(1, 2, 32'hA5A5_0000);
      stall <= 1'b1;
      repeat (30) @(posedge mclk_i);
      fork
         pkt(3, 2, 32'h3300_0000, 1'b1);
         pkt(0, 2, 32'h0000_1110, 1'b1);
      join
      stall <= 1'b0;
      exp_pkt(3, 2, 32'h3300_0000);
      exp_pkt(0, 2, 32'h0000_1110);
   endtask
   task automatic t_ae();
      pkt(0, 3, 32'h5000_0000, 1'b0);
      repeat (60) @(posedge mclk_i);
      check("early transfer", 39'(link.q.size()), 39'h0);
      pkt(0, 1, 32'h5000_0003, 1'b1);
      exp_pkt(0, 4, 32'h5000_0000);
   endtask
   task automatic t_burst();
      logic [38:0] w;
      int i;
      int run;
      stall <= 1'b1;
      reg_wr(REG_CTRL_ADDR, 32'h0110_2304);
      reg_chk(REG_CTRL_ADDR, 32'h0110_2304);
      pkt(2, 17, 32'h2200_0000, 1'b1);
      @(posedge mclk_i);
      @(negedge mclk_i);
      check("fifo full", 39'(rdy[2]), 39'h0);
      stall <= 1'b0;
      i = 0;
      run = 0;
      while (i < 17) begin
         pop(w);
         if (w[38]) begin
            check("burst address", w, wrd(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 32'h2));
            run = 0;
         end else begin
            check("burst word", w, wrd(1'b0, i == 0, i == 16, i == 16,
                                       (i == 16) ? 2'h3 : 2'h0, 32'h2200_0000 + 32'(i)));
            run++;
            i++;
            check("burst length", 39'(run > 2), 39'h0);
         end
      end
   endtask
   initial begin
      n_errors = 0; samples_checked = 0;
      resetn_i = 1'b0; stall = 1'b0; rwr = 1'b0; rrd = 1'b0; ra = 4'h0; rwd = 32'h0;
      wv = 4'h0; we = 4'h0; werr = 4'h0; wd = '0; wm = '0;
      repeat (5) @(posedge mclk_i);
      resetn_i <= 1'b1;
      t_regs();
      t_rr();
      t_ae();
      t_burst();
      final_report();
   end
endmodule
